// ==== rtl/halt_release_cfg.svh ====
`ifndef HALT_RELEASE_CFG_SVH
`define HALT_RELEASE_CFG_SVH

// address shown on the bus while restart is held low
`define RESTART_VECTOR_ADDR 16'hfffe
// second byte of the restart vector
`define RESTART_VECTOR_ADDR_LO 16'hffff
// reset values of the pin-side outputs
`define RW_IDLE_LEVEL 1'b1
`define SYNC_RESET_LEVEL 1'b1
// float pin idles low, so its chain must not come out of reset asserted
`define FLOAT_SYNC_RESET_LEVEL 1'b0

`endif

// ==== rtl/halt_release_pkg.sv ====
package halt_release_pkg;

	// one-hot control states
	typedef enum logic [1:0]
	{
		st_run = 2'b01,
		st_stopped = 2'b10
	} ctrl_state_t;

endpackage

// ==== rtl/pin_sync.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "halt_release_cfg.svh"

// two-flop synchroniser for one asynchronous pin
module pin_sync
#(
	parameter logic RESET_LEVEL = `SYNC_RESET_LEVEL
)
(
	input wire logic core_clk,
	input wire logic reset_n,
	input wire logic pin_in,
	output logic pin_out
);

	logic stage1;

	always_ff @(posedge core_clk)
	begin
		if (!reset_n)
		begin
			stage1 <= RESET_LEVEL;
			pin_out <= RESET_LEVEL;
		end
		else
		begin
			stage1 <= pin_in;
			pin_out <= stage1;
		end
	end

endmodule // pin_sync

`default_nettype wire

// ==== rtl/cpu_halt_bus_release_control.sv ====
// Operation
// - stop request low stops all activity; high lets instructions run
// - bus-released low while executing instructions, high once fully stopped or while waiting for an interrupt
// - bus-released high floats address, data, read/write and forces valid-address low
// - interrupts arriving while stopped are latched and serviced after release
// - restart while stopped: valid-address low, released low, data float, read, FFFE
// - after restart while stopped, release of stop fetches vector FFFE/FFFF
// - a stop request finishes the current instruction; never stops mid-instruction
// - stop request arriving after the sample point stops after the next instruction
// - bus-released rises after the final cycle with the bus floated
// - one-cycle release of stop request steps exactly one instruction
// - bus-released rises again after the stepped instruction's last cycle
// - opcode fetch is cycle one; a step fetches from the next address
// - while waiting for an interrupt, released high, valid-address low, bus floated
// - float control high floats address and read/write, forces strobe and released low
// - restart release loads program counter from FFFE/FFFF
`timescale 1ns/1ps
`default_nettype none
`include "halt_release_cfg.svh"

module cpu_halt_bus_release_control
#(
	parameter int ADDR_W = 16,
	parameter int DATA_W = 8
)
(
	input wire logic core_clk,
	input wire logic reset_n,
	// device pins, asynchronous to core_clk
	input wire logic halt_n,
	input wire logic restart_n,
	input wire logic float_control,
	input wire logic irq_n,
	input wire logic nmi_n,
	// instruction sequencer side, same clock
	input wire logic core_last_cycle,
	input wire logic core_opcode_fetch,
	input wire logic core_waiting,
	input wire logic [ADDR_W-1:0] core_address,
	input wire logic [DATA_W-1:0] core_data,
	input wire logic core_data_drive,
	input wire logic core_rw,
	input wire logic core_vma,
	input wire logic core_irq_ack,
	input wire logic core_nmi_ack,
	output logic core_advance,
	output logic core_restart,
	output logic reset_vector_fetch,
	output logic irq_pending,
	output logic nmi_pending,
	output logic step_fetch,
	// bus pins
	output logic [ADDR_W-1:0] address_lines_out,
	output logic address_lines_oe,
	output logic [DATA_W-1:0] data_lines_out,
	output logic data_lines_oe,
	output logic rw_out,
	output logic rw_oe,
	output logic valid_address_strobe,
	output logic bus_released
);

	logic halt_s;
	logic restart_s;
	logic float_s;
	logic irq_s;
	logic nmi_s;
	logic nmi_prev;
	logic restart_prev;
	logic restart_seen;
	logic stepping;
	halt_release_pkg::ctrl_state_t state;
	halt_release_pkg::ctrl_state_t next_state;

	pin_sync u_sync_halt (.core_clk(core_clk), .reset_n(reset_n), .pin_in(halt_n), .pin_out(halt_s));
	pin_sync u_sync_restart (.core_clk(core_clk), .reset_n(reset_n), .pin_in(restart_n), .pin_out(restart_s));
	pin_sync #(.RESET_LEVEL(`FLOAT_SYNC_RESET_LEVEL)) u_sync_float (.core_clk(core_clk), .reset_n(reset_n),
		.pin_in(float_control), .pin_out(float_s));
	pin_sync u_sync_irq (.core_clk(core_clk), .reset_n(reset_n), .pin_in(irq_n), .pin_out(irq_s));
	pin_sync u_sync_nmi (.core_clk(core_clk), .reset_n(reset_n), .pin_in(nmi_n), .pin_out(nmi_s));

	wire restart_active = !restart_s;
	wire restart_release = restart_s && !restart_prev;
	wire nmi_edge = !nmi_s && nmi_prev;
	// stop request looked at only at the boundary point of the final cycle
	wire boundary_sample = core_last_cycle && (state == halt_release_pkg::st_run);
	wire stop_now = boundary_sample && !halt_s;
	wire resume_now = (state == halt_release_pkg::st_stopped) && halt_s;
	wire next_stopped = (next_state == halt_release_pkg::st_stopped);
	wire vector_now = resume_now && (restart_seen || restart_release) && !restart_active;
	wire free_vector = restart_release && !next_stopped;
	wire released_now = (next_stopped || core_waiting) && !restart_active && !float_s;

	always_comb
	begin
		next_state = state;
		unique case (state)
			halt_release_pkg::st_run:
			begin
				if (stop_now)
					next_state = halt_release_pkg::st_stopped;
			end
			halt_release_pkg::st_stopped:
			begin
				if (halt_s)
					next_state = halt_release_pkg::st_run;
			end
		endcase
	end

	always_ff @(posedge core_clk)
	begin
		if (!reset_n)
			state <= halt_release_pkg::st_run;
		else
			state <= next_state;
	end

	// restart seen while stopped waits for the stop request to go away
	always_ff @(posedge core_clk)
	begin
		if (!reset_n)
		begin
			restart_prev <= 1'b1;
			restart_seen <= 1'b0;
		end
		else
		begin
			restart_prev <= restart_s;
			if (restart_active && next_stopped)
				restart_seen <= 1'b1;
			else if (vector_now)
				restart_seen <= 1'b0;
		end
	end

	always_ff @(posedge core_clk)
	begin
		if (!reset_n)
			reset_vector_fetch <= 1'b0;
		else
			reset_vector_fetch <= vector_now || free_vector;
	end

	// interrupts latched while stopped; a new event beats the acknowledge
	always_ff @(posedge core_clk)
	begin
		if (!reset_n)
		begin
			nmi_prev <= 1'b1;
			nmi_pending <= 1'b0;
			irq_pending <= 1'b0;
		end
		else
		begin
			nmi_prev <= nmi_s;
			if (nmi_edge)
				nmi_pending <= 1'b1;
			else if (core_nmi_ack && state == halt_release_pkg::st_run)
				nmi_pending <= 1'b0;
			if (!irq_s)
				irq_pending <= 1'b1;
			else if (core_irq_ack && state == halt_release_pkg::st_run)
				irq_pending <= 1'b0;
		end
	end

	// a one-cycle release marks the next opcode fetch as a step
	always_ff @(posedge core_clk)
	begin
		if (!reset_n)
		begin
			stepping <= 1'b0;
			step_fetch <= 1'b0;
		end
		else
		begin
			if (resume_now)
				stepping <= 1'b1;
			else if (core_opcode_fetch && core_advance)
				stepping <= 1'b0;
			step_fetch <= stepping && core_opcode_fetch && core_advance;
		end
	end

	always_ff @(posedge core_clk)
	begin
		if (!reset_n)
		begin
			core_advance <= 1'b1;
			core_restart <= 1'b0;
		end
		else
		begin
			core_advance <= !next_stopped && !float_s;
			core_restart <= restart_active;
		end
	end

	// output state selection: restart, then float control, then released
	always_ff @(posedge core_clk)
	begin
		if (!reset_n)
		begin
			bus_released <= 1'b0;
			valid_address_strobe <= 1'b0;
			address_lines_out <= ADDR_W'(`RESTART_VECTOR_ADDR);
			address_lines_oe <= 1'b0;
			data_lines_out <= '0;
			data_lines_oe <= 1'b0;
			rw_out <= `RW_IDLE_LEVEL;
			rw_oe <= 1'b0;
		end
		else if (restart_active)
		begin
			bus_released <= 1'b0;
			valid_address_strobe <= 1'b0;
			address_lines_out <= ADDR_W'(`RESTART_VECTOR_ADDR);
			address_lines_oe <= 1'b1;
			data_lines_out <= '0;
			data_lines_oe <= 1'b0;
			rw_out <= `RW_IDLE_LEVEL;
			rw_oe <= 1'b1;
		end
		else if (float_s)
		begin
			bus_released <= 1'b0;
			valid_address_strobe <= 1'b0;
			address_lines_out <= core_address;
			address_lines_oe <= 1'b0;
			data_lines_out <= core_data;
			data_lines_oe <= core_data_drive;
			rw_out <= core_rw;
			rw_oe <= 1'b0;
		end
		else if (released_now)
		begin
			bus_released <= 1'b1;
			valid_address_strobe <= 1'b0;
			address_lines_out <= core_address;
			address_lines_oe <= 1'b0;
			data_lines_out <= core_data;
			data_lines_oe <= 1'b0;
			rw_out <= core_rw;
			rw_oe <= 1'b0;
		end
		else
		begin
			bus_released <= 1'b0;
			valid_address_strobe <= core_vma;
			address_lines_out <= core_address;
			address_lines_oe <= 1'b1;
			data_lines_out <= core_data;
			data_lines_oe <= core_data_drive;
			rw_out <= core_rw;
			rw_oe <= 1'b1;
		end
	end

endmodule // cpu_halt_bus_release_control

`default_nettype wire

// ==== bench/halt_release_asserts.sv ====
`timescale 1ns/1ps
`default_nettype none
module halt_release_asserts
(
	input wire logic core_clk,
	input wire logic reset_n,
	input wire logic halt_n,
	input wire logic restart_n,
	input wire logic float_control,
	input wire logic irq_n,
	input wire logic core_last_cycle,
	input wire logic core_waiting,
	input wire logic core_advance,
	input wire logic irq_pending,
	input wire logic [15:0] address_lines_out,
	input wire logic address_lines_oe,
	input wire logic data_lines_oe,
	input wire logic rw_out,
	input wire logic rw_oe,
	input wire logic valid_address_strobe,
	input wire logic bus_released
);
	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (!reset_n);
	wire logic off = !address_lines_oe && !rw_oe && !valid_address_strobe;
	sequence s_stop_req;
		(!halt_n && restart_n && !float_control)[*3] ##0 (core_last_cycle && core_advance);
	endsequence
	sequence s_mid_instr;
		(!float_control)[*3] ##0 (core_advance && !core_last_cycle);
	endsequence
	a_no_midstop: assert property (s_mid_instr |=> core_advance)
		else $error("stopped inside an instruction");
	a_released_floats: assert property (bus_released |-> off && !data_lines_oe && (!core_advance || $past(core_waiting)))
		else $error("bus not floated");
	a_stop_boundary: assert property (s_stop_req |-> ##2 (bus_released && !core_advance))
		else $error("no stop at boundary");
	a_restart_forces: assert property ((!restart_n)[*4] |-> address_lines_out == 16'hfffe
		&& address_lines_oe && rw_out && rw_oe && !valid_address_strobe && !bus_released && !data_lines_oe)
		else $error("restart outputs wrong");
	a_float_forces: assert property ((float_control && restart_n)[*4] |-> off && !bus_released)
		else $error("float not applied");
	a_wait_floats: assert property ((core_waiting && restart_n && !float_control)[*4] |-> off && bus_released)
		else $error("wait not floated");
	a_irq_latched: assert property ((!irq_n)[*3] |=> irq_pending)
		else $error("interrupt not latched");
	a_pending_kept: assert property ((!halt_n)[*4] ##0 (irq_pending && bus_released) |=> irq_pending)
		else $error("interrupt lost");
	a_run_level: assert property ((halt_n && restart_n && !float_control && !core_waiting)[*5] |-> !bus_released)
		else $error("released while running");
endmodule // halt_release_asserts
bind cpu_halt_bus_release_control halt_release_asserts checker_i (.*);
`default_nettype wire

// ==== bench/stop_master.sv ====
`timescale 1ns/1ps
`default_nettype none
// mode 0 runs, 1 holds stopped, 2 releases for one cycle
module stop_master
(
	input wire logic core_clk,
	input wire logic [1:0] mode,
	output logic halt_n = 1'b1
);
	logic stepped = 1'b0;
	always @(posedge core_clk)
	begin
		halt_n <= mode == 2'h0 || (mode == 2'h2 && !stepped);
		stepped <= mode == 2'h2;
	end
endmodule // stop_master
`default_nettype wire

// ==== bench/tb_cpu_halt_bus_release_control.sv ====
`timescale 1ns/1ps
`default_nettype none
module tb_cpu_halt_bus_release_control;
	logic core_clk = 1'b0, reset_n = 1'b0, restart_n = 1'b1, float_control = 1'b0, irq_n = 1'b1, nmi_n = 1'b1;
	logic core_waiting = 1'b0, core_data_drive = 1'b0, core_rw = 1'b1, core_vma = 1'b0;
	logic core_irq_ack = 1'b0, core_nmi_ack = 1'b0, halt_n, core_last_cycle, core_opcode_fetch;
	logic core_advance, core_restart, reset_vector_fetch, irq_pending, nmi_pending, step_fetch;
	logic address_lines_oe, data_lines_oe, rw_out, rw_oe, valid_address_strobe, bus_released;
	logic [15:0] core_address = 16'h0000, address_lines_out;
	logic [7:0] core_data = 8'h00, data_lines_out;
	logic [1:0] mode = 2'h0;
	logic [15:0] last_addr;
	logic [7:0] last_data;
	logic last_rw, last_vma, last_drive;
	int fails = 0, n_tests = 0, done = 0, len = 2, cnt = 0, t, d, n_steps = 0;
	assign core_opcode_fetch = cnt == 0;
	assign core_last_cycle = cnt == len - 1;
	cpu_halt_bus_release_control uut (.*);
	stop_master master (.*);
	always #50 core_clk = ~core_clk;
	// sequencer model: counts finished instructions of two or three cycles
	always @(posedge core_clk)
	begin
		core_address <= 16'($urandom);
		core_rw <= 1'($urandom);
		core_data <= 8'($urandom);
		core_vma <= 1'($urandom);
		core_data_drive <= 1'($urandom);
		last_addr <= core_address;
		last_data <= core_data;
		last_rw <= core_rw;
		last_vma <= core_vma;
		last_drive <= core_data_drive;
		if (reset_n)
			n_steps <= n_steps + int'(step_fetch);
		if (reset_n && core_advance === 1'b1)
		begin
			done <= done + int'(core_last_cycle);
			cnt <= core_last_cycle ? 0 : cnt + 1;
			if (core_last_cycle)
				len <= 2 + $urandom % 2;
		end
	end
	task automatic tick(input int n);
		repeat (n) @(posedge core_clk);
	endtask
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp)
		begin
			fails++;
			$display("MISMATCH %0t: saw %h want %h", $time, seen, exp);
		end
	endtask
	task automatic wait_for(ref logic s, input logic v);
		for (t = 0; t < 40 && s !== v; t++)
			@(negedge core_clk);
		if (t == 40)
		begin
			fails++;
			conclude();
		end
	endtask
	task automatic conclude;
		$display("comparisons %0d mismatches %0d", n_tests, fails);
		if (fails == 0 && n_tests > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	initial
	begin
		d = $urandom(67727);
		tick(6);
		reset_n <= 1'b1;
		tick(12);
		mode <= 2'h1;
		wait_for(bus_released, 1'b1);
		d = done;
		tick(8);
		irq_n <= 1'b0;
		nmi_n <= 1'b0;
		core_irq_ack <= 1'b1;
		core_nmi_ack <= 1'b1;
		tick(4);
		irq_n <= 1'b1;
		nmi_n <= 1'b1;
		tick(4);
		@(negedge core_clk);
		check(done, d);
		check({address_lines_oe, data_lines_oe, rw_oe, valid_address_strobe}, 0);
		check(irq_pending, 1);
		check(nmi_pending, 1);
		tick(1);
		mode <= 2'h2;
		tick(1);
		mode <= 2'h1;
		wait_for(bus_released, 1'b0);
		wait_for(bus_released, 1'b1);
		check(done, d + 1);
		check(irq_pending, 0);
		check(nmi_pending, 0);
		check(n_steps, 1);
		tick(1);
		core_irq_ack <= 1'b0;
		core_nmi_ack <= 1'b0;
		restart_n <= 1'b0;
		tick(5);
		@(negedge core_clk);
		check(address_lines_out, 16'hfffe);
		check(core_restart, 1);
		check({address_lines_oe, rw_out, rw_oe, bus_released, valid_address_strobe, data_lines_oe}, 6'h38);
		tick(1);
		restart_n <= 1'b1;
		tick(5);
		mode <= 2'h0;
		wait_for(reset_vector_fetch, 1'b1);
		check(reset_vector_fetch, 1);
		@(negedge core_clk);
		check(reset_vector_fetch, 0);
		check({address_lines_out, data_lines_out}, {last_addr, last_data});
		check({address_lines_oe, rw_out, rw_oe, data_lines_oe, valid_address_strobe, bus_released},
			{1'b1, last_rw, 1'b1, last_drive, last_vma, 1'b0});
		tick(1);
		float_control <= 1'b1;
		tick(5);
		@(negedge core_clk);
		check({address_lines_oe, rw_oe, valid_address_strobe, bus_released, core_advance}, 0);
		tick(1);
		float_control <= 1'b0;
		core_waiting <= 1'b1;
		tick(6);
		@(negedge core_clk);
		check({bus_released, valid_address_strobe, address_lines_oe, data_lines_oe}, 4'h8);
		tick(1);
		core_waiting <= 1'b0;
		restart_n <= 1'b0;
		tick(5);
		restart_n <= 1'b1;
		wait_for(reset_vector_fetch, 1'b1);
		check(reset_vector_fetch, 1);
		check(core_restart, 0);
		conclude();
	end
endmodule // tb_cpu_halt_bus_release_control
`default_nettype wire
